// File: logic/mpm_mapper.sv
// process image mapper: mapping tables, image packing, exchange arrays
// assumes one register beat per request, beats of a message in address order
`timescale 1ns/1ps
module mpm_mapper (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register beat request
    input wire logic req_valid,
    input wire mpm_pkg::mpm_req_t req,
    // register beat answer
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic [7:0] rsp_exc,
    // mapping object writes
    input wire logic obj_valid,
    input wire mpm_pkg::mpm_obj_t obj,
    output logic obj_ack,
    output logic [7:0] obj_exc,
    // drive object values
    input wire mpm_pkg::mpm_vals_t tx_vals,
    output mpm_pkg::mpm_vals_t rx_vals,
    output logic rx_update,
    // user program exchange
    input wire mpm_pkg::mpm_arr_t up_out,
    output mpm_pkg::mpm_arr_t up_in
);
    // bytes carried by an entry, valid lengths only
    function automatic logic [2:0] ent_bytes(input logic [31:0] e);
        return e[mpm_pkg::ENT_LEN_LSB+3 +: 3];
    endfunction : ent_bytes

    // dummy objects by index
    function automatic logic is_dummy(input logic [31:0] e);
        logic [15:0] idx;
        idx = e[mpm_pkg::ENT_IDX_LSB +: 16];
        return (idx >= mpm_pkg::DUMMY_LO) && (idx <= mpm_pkg::DUMMY_HI);
    endfunction : is_dummy

    // length accepted for a mapping entry
    function automatic logic len_ok(input logic [31:0] e);
        logic [7:0] len;
        len = e[mpm_pkg::ENT_LEN_LSB +: 8];
        return (len == mpm_pkg::LEN_8) || (len == mpm_pkg::LEN_16) || (len == mpm_pkg::LEN_32);
    endfunction : len_ok

    // byte offset of entry i, packed without gaps
    function automatic logic [6:0] ent_off(input int i, input mpm_pkg::mpm_vals_t tab);
        logic [6:0] off;
        off = 7'h00;
        for (int j = 0; j < mpm_pkg::MAP_SLOTS; j++) begin
            if (j < i) begin
                off = off + 7'(ent_bytes(tab[j]));
            end
        end
        return off;
    endfunction : ent_off

    // total image length in bytes
    function automatic logic [6:0] img_len(input mpm_pkg::mpm_vals_t tab, input logic [4:0] cnt);
        return ent_off(int'(cnt), tab);
    endfunction : img_len

    // transmit byte k, most significant byte of each value first
    function automatic logic [7:0] tx_byte(input logic [6:0] k,
            input mpm_pkg::mpm_vals_t tab, input logic [4:0] cnt,
            input mpm_pkg::mpm_vals_t vals);
        logic [6:0] off;
        logic [2:0] n;
        logic [1:0] pos;
        logic [7:0] b;
        off = 7'h00;
        b = 8'h00;
        for (int i = 0; i < mpm_pkg::MAP_SLOTS; i++) begin
            n = ent_bytes(tab[i]);
            if ((i < int'(cnt)) && (k >= off) && (k < off + 7'(n))) begin
                pos = 2'(n - 3'h1 - 3'(k - off));
                if (!is_dummy(tab[i])) begin
                    b = vals[i][8*pos +: 8];
                end
            end
            off = off + 7'(n);
        end
        return b;
    endfunction : tx_byte

    // value of receive entry i gathered from the image buffer
    function automatic logic [31:0] rx_value(input int i, input mpm_pkg::mpm_vals_t tab,
            input logic [4:0] cnt, input mpm_pkg::mpm_buf_t buf_in);
        logic [6:0] off;
        logic [31:0] v;
        off = ent_off(i, tab);
        v = 32'h0000_0000;
        if ((i < int'(cnt)) && !is_dummy(tab[i])) begin
            for (int j = 0; j < 4; j++) begin
                if (j < int'(ent_bytes(tab[i]))) begin
                    v = {v[23:0], buf_in[6'(off + 7'(j))]};
                end
            end
        end
        return v;
    endfunction : rx_value

    // register window of an address
    function automatic mpm_pkg::mpm_region_t region_of(input logic [15:0] a);
        if (a >= mpm_pkg::TX_BASE && a < mpm_pkg::TX_BASE + mpm_pkg::IMG_REGS) begin
            return mpm_pkg::REG_TX;
        end else if (a >= mpm_pkg::RX_BASE && a < mpm_pkg::RX_BASE + mpm_pkg::IMG_REGS) begin
            return mpm_pkg::REG_RX;
        end else if (a >= mpm_pkg::UIN_BASE && a < mpm_pkg::UIN_BASE + mpm_pkg::ARR_REGS) begin
            return mpm_pkg::REG_UIN;
        end else if (a >= mpm_pkg::UOUT_BASE && a < mpm_pkg::UOUT_BASE + mpm_pkg::ARR_REGS) begin
            return mpm_pkg::REG_UOUT;
        end
        return mpm_pkg::REG_NONE;
    endfunction : region_of

    // base register of a window
    function automatic logic [15:0] base_of(input mpm_pkg::mpm_region_t r);
        case (r)
            mpm_pkg::REG_TX: return mpm_pkg::TX_BASE;
            mpm_pkg::REG_RX: return mpm_pkg::RX_BASE;
            mpm_pkg::REG_UIN: return mpm_pkg::UIN_BASE;
            mpm_pkg::REG_UOUT: return mpm_pkg::UOUT_BASE;
            default: return 16'h0000;
        endcase
    endfunction : base_of

    // mapping tables and counts
    mpm_pkg::mpm_vals_t tx_tab_reg;
    mpm_pkg::mpm_vals_t rx_tab_reg;
    logic [4:0] tx_cnt_reg;
    logic [4:0] rx_cnt_reg;
    // receive image bytes and exchange storage
    mpm_pkg::mpm_buf_t rx_buf_reg;
    mpm_pkg::mpm_arr_t uin_reg;
    logic [15:0] stage_reg;
    // answer registers
    logic rsp_valid_reg;
    logic [15:0] rsp_data_reg;
    logic [7:0] rsp_exc_reg;
    logic obj_ack_reg;
    logic [7:0] obj_exc_reg;
    logic rx_update_reg;
    mpm_pkg::mpm_vals_t rx_vals_reg;

    // beat decode
    mpm_pkg::mpm_region_t reg_st;
    mpm_pkg::mpm_region_t reg_bt;
    logic [15:0] rel_st;
    logic [15:0] rel;
    logic [16:0] end_rel;
    logic [15:0] limit;
    logic is_img;
    logic is_arr;
    logic fc_rd;
    logic fc_wr;
    logic fc_ok;
    logic [7:0] exc_next;
    logic beat_ok;
    logic [6:0] kb;
    logic [15:0] rd_next;
    logic [4:0] wi;

    assign reg_st = region_of(req.start);
    assign reg_bt = region_of(req.addr);
    assign rel_st = req.start - base_of(reg_st);
    assign rel = req.addr - base_of(reg_st);
    assign end_rel = {1'b0, rel_st} + {1'b0, req.qty};
    assign is_img = (reg_st == mpm_pkg::REG_TX) || (reg_st == mpm_pkg::REG_RX);
    assign is_arr = (reg_st == mpm_pkg::REG_UIN) || (reg_st == mpm_pkg::REG_UOUT);
    // image length in registers, rounded up
    assign limit = !is_img ? mpm_pkg::ARR_REGS :
        (reg_st == mpm_pkg::REG_TX) ? 16'((img_len(tx_tab_reg, tx_cnt_reg) + 7'h01) >> 1) :
        16'((img_len(rx_tab_reg, rx_cnt_reg) + 7'h01) >> 1);
    assign fc_rd = (req.fc == mpm_pkg::FC_RD_HOLD) || (req.fc == mpm_pkg::FC_RD_IN) ||
        (req.fc == mpm_pkg::FC_RW_MULTI);
    assign fc_wr = (req.fc == mpm_pkg::FC_WR_ONE) || (req.fc == mpm_pkg::FC_WR_MULTI) ||
        (req.fc == mpm_pkg::FC_RW_MULTI);
    assign fc_ok = req.wr ? fc_wr : fc_rd;
    // exception priority: function, window, direction, quantity, alignment, extent
    assign exc_next = (!fc_ok || (is_arr && req.fc == mpm_pkg::FC_WR_ONE)) ? mpm_pkg::EXC_FUNC :
        (reg_st == mpm_pkg::REG_NONE || reg_bt != reg_st) ? mpm_pkg::EXC_ADDR :
        (req.wr && (reg_st == mpm_pkg::REG_TX || reg_st == mpm_pkg::REG_UOUT)) ?
        mpm_pkg::EXC_ADDR :
        (req.qty == 16'h0000) ? mpm_pkg::EXC_VALUE :
        (is_arr && (rel_st[0] || (req.wr && req.qty[0]))) ? mpm_pkg::EXC_ADDR :
        (end_rel > {1'b0, limit}) ? mpm_pkg::EXC_ADDR :
        mpm_pkg::EXC_NONE;
    assign beat_ok = req_valid && (exc_next == mpm_pkg::EXC_NONE);
    assign kb = {rel[5:0], 1'b0};
    assign wi = rel[5:1];
    // read data per window, high half of a word at the even register
    assign rd_next = (reg_st == mpm_pkg::REG_TX) ?
        {tx_byte(kb, tx_tab_reg, tx_cnt_reg, tx_vals),
        tx_byte(kb + 7'h01, tx_tab_reg, tx_cnt_reg, tx_vals)} :
        (reg_st == mpm_pkg::REG_RX) ? {rx_buf_reg[kb[5:0]], rx_buf_reg[kb[5:0] + 6'h01]} :
        (reg_st == mpm_pkg::REG_UIN) ? (rel[0] ? uin_reg[wi][15:0] : uin_reg[wi][31:16]) :
        (rel[0] ? up_out[wi][15:0] : up_out[wi][31:16]);

    // object write decode
    logic obj_map;
    logic obj_is_tx;
    logic obj_val_ok;
    logic [7:0] obj_exc_next;
    logic obj_ok;
    logic [3:0] slot;
    assign obj_is_tx = (obj.index == mpm_pkg::TX_MAP_OBJ);
    assign obj_map = obj_is_tx || (obj.index == mpm_pkg::RX_MAP_OBJ);
    assign obj_val_ok = (obj.sub == mpm_pkg::SUB_CNT) ? (obj.data <= mpm_pkg::MAP_CNT_MAX) :
        ((obj.sub <= mpm_pkg::SUB_MAX) && len_ok(obj.data));
    assign obj_exc_next = (obj.fc != mpm_pkg::FC_OBJ) ? mpm_pkg::EXC_FUNC :
        !obj_map ? mpm_pkg::EXC_ADDR :
        !obj_val_ok ? mpm_pkg::EXC_VALUE : mpm_pkg::EXC_NONE;
    assign obj_ok = obj_valid && (obj_exc_next == mpm_pkg::EXC_NONE);
    assign slot = 4'(obj.sub - 8'h01);

    // mapping table updates
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tx_tab_reg <= '0;
            rx_tab_reg <= '0;
            tx_cnt_reg <= mpm_pkg::CNT_RST;
            rx_cnt_reg <= mpm_pkg::CNT_RST;
        end else if (obj_ok && obj.sub == mpm_pkg::SUB_CNT) begin
            if (obj_is_tx) begin
                tx_cnt_reg <= obj.data[4:0];
            end else begin
                rx_cnt_reg <= obj.data[4:0];
            end
        end else if (obj_ok) begin
            if (obj_is_tx) begin
                tx_tab_reg[slot] <= obj.data;
            end else begin
                rx_tab_reg[slot] <= obj.data;
            end
        end
    end

    // receive image and input array writes
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rx_buf_reg <= '0;
            uin_reg <= '0;
            stage_reg <= 16'h0000;
        end else if (beat_ok && req.wr && reg_st == mpm_pkg::REG_RX) begin
            rx_buf_reg[kb[5:0]] <= req.wdata[15:8];
            rx_buf_reg[kb[5:0] + 6'h01] <= req.wdata[7:0];
        end else if (beat_ok && req.wr && reg_st == mpm_pkg::REG_UIN && !rel[0]) begin
            stage_reg <= req.wdata;
        end else if (beat_ok && req.wr && reg_st == mpm_pkg::REG_UIN) begin
            uin_reg[wi] <= {stage_reg, req.wdata};
        end
    end

    // answers, one cycle after each request
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 16'h0000;
            rsp_exc_reg <= mpm_pkg::EXC_NONE;
            obj_ack_reg <= 1'b0;
            obj_exc_reg <= mpm_pkg::EXC_NONE;
            rx_update_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= req_valid;
            rsp_data_reg <= (beat_ok && !req.wr) ? rd_next : 16'h0000;
            rsp_exc_reg <= req_valid ? exc_next : mpm_pkg::EXC_NONE;
            obj_ack_reg <= obj_valid;
            obj_exc_reg <= obj_valid ? obj_exc_next : mpm_pkg::EXC_NONE;
            rx_update_reg <= beat_ok && req.wr && (reg_st == mpm_pkg::REG_RX) &&
                (req.addr == 16'(req.start + req.qty - 16'h0001));
        end
    end

    // receive values unpacked per entry
    for (genvar g = 0; g < mpm_pkg::MAP_SLOTS; g++) begin : g_rx
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                rx_vals_reg[g] <= mpm_pkg::WORD_RST;
            end else begin
                rx_vals_reg[g] <= rx_value(g, rx_tab_reg, rx_cnt_reg, rx_buf_reg);
            end
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
    assign rsp_exc = rsp_exc_reg;
    assign obj_ack = obj_ack_reg;
    assign obj_exc = obj_exc_reg;
    assign rx_update = rx_update_reg;
    assign rx_vals = rx_vals_reg;
    assign up_in = uin_reg;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_rsp_timing: assert property (req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
        else $error("answer does not follow request by one cycle");
    chk_array_fc06: assert property (req_valid && is_arr && req.fc == mpm_pkg::FC_WR_ONE |=>
        rsp_exc == mpm_pkg::EXC_FUNC) else $error("single write to array not refused");
    chk_tx_readonly: assert property (req_valid && req.wr && fc_ok && reg_st == mpm_pkg::REG_TX
        && reg_bt == reg_st |=> rsp_exc == mpm_pkg::EXC_ADDR) else $error("tx write accepted");
    chk_img_bounds: assert property (req_valid && fc_ok && !req.wr && is_img && reg_bt == reg_st
        && end_rel > {1'b0, limit} |=> rsp_exc != mpm_pkg::EXC_NONE && rsp_data == 16'h0000)
        else $error("image overrun not refused");
    chk_dummy_zero: assert property (req_valid && !req.wr && req.addr == mpm_pkg::TX_BASE &&
        fc_ok && tx_cnt_reg != 5'h00 && is_dummy(tx_tab_reg[0]) &&
        ent_bytes(tx_tab_reg[0]) >= 3'h2 |=> rsp_data == 16'h0000)
        else $error("dummy slot not zero");
    chk_map_count: assert property (obj_valid && obj.fc == mpm_pkg::FC_OBJ && obj_is_tx &&
        obj.sub == mpm_pkg::SUB_CNT && obj.data > mpm_pkg::MAP_CNT_MAX |=>
        obj_exc == mpm_pkg::EXC_VALUE && $stable(tx_cnt_reg)) else $error("count over 16 taken");
    chk_map_fc: assert property (obj_valid && obj.fc != mpm_pkg::FC_OBJ |=>
        obj_ack && obj_exc == mpm_pkg::EXC_FUNC && $stable(tx_tab_reg) && $stable(rx_tab_reg))
        else $error("mapping written without 2B");
    chk_uin_commit: assert property (beat_ok && req.wr && reg_st == mpm_pkg::REG_UIN &&
        rel[0] |=> up_in[$past(wi)] == {$past(stage_reg), $past(req.wdata)})
        else $error("input array word not committed");
    chk_rx_update: assert property (rx_update |-> $past(beat_ok) && $past(req.wr) &&
        $past(reg_st) == mpm_pkg::REG_RX) else $error("stray receive update");
    chk_tx_order: assert property (req_valid && !req.wr && req.addr == mpm_pkg::TX_BASE &&
        fc_ok && reg_st == mpm_pkg::REG_TX && req.qty != 16'h0000 && tx_cnt_reg != 5'h00 &&
        !is_dummy(tx_tab_reg[0]) &&
        ent_bytes(tx_tab_reg[0]) == 3'h2 && end_rel <= {1'b0, limit} |=>
        rsp_data == $past(tx_vals[0][15:0])) else $error("tx byte order wrong");

    cov_tx_read: cover property (beat_ok && !req.wr && reg_st == mpm_pkg::REG_TX);
    cov_rx_update: cover property (rx_update);
    cov_map_write: cover property (obj_ok && obj_is_tx);
    cov_uin_word: cover property (beat_ok && req.wr && reg_st == mpm_pkg::REG_UIN && rel[0]);
endmodule : mpm_mapper

// File: shared/mpm_pkg.sv
// constants, field layout and carrier types of the process image mapper
// assumes a front end that splits each modbus message into register beats
package mpm_pkg;
    // mapping objects and their shape
    localparam logic [15:0] RX_MAP_OBJ = 16'h3502;
    localparam logic [15:0] TX_MAP_OBJ = 16'h3602;
    localparam int MAP_SLOTS = 16;
    localparam logic [31:0] MAP_CNT_MAX = 32'h0000_0010;
    localparam logic [7:0] SUB_CNT = 8'h00;
    localparam logic [7:0] SUB_MAX = 8'h10;
    localparam logic [15:0] DUMMY_LO = 16'h0002;
    localparam logic [15:0] DUMMY_HI = 16'h0007;
    // entry field positions
    localparam int ENT_IDX_LSB = 16;
    localparam int ENT_SUB_LSB = 8;
    localparam int ENT_LEN_LSB = 0;
    localparam logic [7:0] LEN_8 = 8'h08;
    localparam logic [7:0] LEN_16 = 8'h10;
    localparam logic [7:0] LEN_32 = 8'h20;
    // function codes
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_IN = 8'h04;
    localparam logic [7:0] FC_WR_ONE = 8'h06;
    localparam logic [7:0] FC_WR_MULTI = 8'h10;
    localparam logic [7:0] FC_RW_MULTI = 8'h17;
    localparam logic [7:0] FC_OBJ = 8'h2B;
    // register windows
    localparam logic [15:0] TX_BASE = 16'h1388;
    localparam logic [15:0] RX_BASE = 16'h1770;
    localparam logic [15:0] UIN_BASE = 16'h07D0;
    localparam logic [15:0] UOUT_BASE = 16'h0BB8;
    localparam logic [15:0] IMG_REGS = 16'h0020;
    localparam logic [15:0] ARR_REGS = 16'h0040;
    localparam int IMG_BYTES = 64;
    localparam int ARR_WORDS = 32;
    // exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    // reset values
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // one register beat of a message
    typedef struct packed {
        logic [7:0] fc;
        logic wr;
        logic [15:0] start;
        logic [15:0] qty;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mpm_req_t;
    // one object write carried by function 2B
    typedef struct packed {
        logic [7:0] fc;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } mpm_obj_t;
    typedef logic [MAP_SLOTS-1:0][31:0] mpm_vals_t;
    typedef logic [ARR_WORDS-1:0][31:0] mpm_arr_t;
    typedef logic [IMG_BYTES-1:0][7:0] mpm_buf_t;
    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_TX = 3'h1,
        REG_RX = 3'h3,
        REG_UIN = 3'h2,
        REG_UOUT = 3'h6
    } mpm_region_t;
endpackage : mpm_pkg

// File: test/modbus_process_image_mapper_bench.sv
// self-checking bench of the process image mapper
// assumes mpm_mapper and the master model mpm_master; one 20 MHz clock
`timescale 1ns/1ps
module modbus_process_image_mapper_bench;
    logic ref_clk, resetn, req_valid, rsp_valid, obj_valid, obj_ack, rx_update;
    mpm_pkg::mpm_req_t req;
    mpm_pkg::mpm_obj_t obj;
    logic [15:0] rsp_data;
    logic [7:0] rsp_exc, obj_exc;
    mpm_pkg::mpm_vals_t tx_vals, rx_vals;
    mpm_pkg::mpm_arr_t up_out, up_in;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0; // timeout counter
    // tx entries of the six-value example, and a small rx table
    logic [31:0] tx_map [6] = '{32'h6041_0010, 32'h0005_0008, 32'h6061_0008,
                                32'h6064_0020, 32'h6044_0010, 32'h60FD_0020};
    logic [15:0] tx_img [7] = '{16'h1234, 16'h0056, 16'h89AB, 16'hCDEF,
                                16'h4321, 16'h1122, 16'h3344};
    logic [31:0] rx_map [3] = '{32'h6040_0010, 32'h0006_0010, 32'h607A_0020};
    // refused messages: fc, wr, start, qty, exception
    logic [48:0] bad [10] = '{
        {mpm_pkg::FC_WR_MULTI, 1'b1, mpm_pkg::TX_BASE, 16'h0001, mpm_pkg::EXC_ADDR},
        {mpm_pkg::FC_RD_IN, 1'b0, mpm_pkg::TX_BASE, 16'h0008, mpm_pkg::EXC_ADDR},
        {mpm_pkg::FC_RD_HOLD, 1'b0, mpm_pkg::TX_BASE, 16'h0000, mpm_pkg::EXC_VALUE},
        {mpm_pkg::FC_WR_ONE, 1'b1, mpm_pkg::UIN_BASE, 16'h0001, mpm_pkg::EXC_FUNC},
        {mpm_pkg::FC_WR_MULTI, 1'b1, 16'h07D1, 16'h0002, mpm_pkg::EXC_ADDR},
        {mpm_pkg::FC_WR_MULTI, 1'b1, mpm_pkg::UIN_BASE, 16'h0001, mpm_pkg::EXC_ADDR},
        {mpm_pkg::FC_WR_MULTI, 1'b1, mpm_pkg::UOUT_BASE, 16'h0002, mpm_pkg::EXC_ADDR},
        {mpm_pkg::FC_RD_HOLD, 1'b0, 16'h080E, 16'h0004, mpm_pkg::EXC_ADDR},
        {mpm_pkg::FC_OBJ, 1'b0, mpm_pkg::TX_BASE, 16'h0001, mpm_pkg::EXC_FUNC},
        {mpm_pkg::FC_WR_MULTI, 1'b1, mpm_pkg::RX_BASE, 16'h0005, mpm_pkg::EXC_ADDR}};
    // refused object writes: fc, index, sub, data, exception
    logic [71:0] bado [5] = '{
        {8'h2A, mpm_pkg::RX_MAP_OBJ, 8'h01, 32'h6040_0010, mpm_pkg::EXC_FUNC},
        {mpm_pkg::FC_OBJ, 16'h3503, 8'h01, 32'h6040_0010, mpm_pkg::EXC_ADDR},
        {mpm_pkg::FC_OBJ, mpm_pkg::RX_MAP_OBJ, 8'h00, 32'h0000_0011, mpm_pkg::EXC_VALUE},
        {mpm_pkg::FC_OBJ, mpm_pkg::RX_MAP_OBJ, 8'h11, 32'h6040_0010, mpm_pkg::EXC_VALUE},
        {mpm_pkg::FC_OBJ, mpm_pkg::RX_MAP_OBJ, 8'h01, 32'h6040_000C, mpm_pkg::EXC_VALUE}};
    logic [7:0] f, e, ob_f, ob_s;
    logic w;
    logic [15:0] s, q, ob_i;
    logic [31:0] ob_d;
    // design and master model
    mpm_mapper DUT (.ref_clk, .resetn, .req_valid, .req, .rsp_valid, .rsp_data,
        .rsp_exc, .obj_valid, .obj, .obj_ack, .obj_exc, .tx_vals, .rx_vals,
        .rx_update, .up_out, .up_in);
    mpm_master mst (.ref_clk, .req_valid, .req, .rsp_valid, .rsp_data, .rsp_exc,
        .rx_update, .obj_valid, .obj, .obj_ack, .obj_exc);
    // value compare
    task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask : cmp
    // exception code compare
    task automatic cx(input string nm, input logic [7:0] x, input logic [7:0] g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %s exc exp %h got %h", nm, x, g);
        end
    endtask : cx
    // verdict and end of run
    task automatic conclude();
        if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    // 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    // main sequence
    initial begin
        resetn = 1'b0;
        tx_vals = '0;
        up_out = '0;
        up_out[1] = 32'hCAFE_F00D;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        cmp("reset", 32'h0, up_in[0] | rx_vals[0] | {rsp_valid, obj_ack, rx_update});
        // tx image; slot 2 is a dummy holding a nonzero value
        tx_vals[0] = 32'h0000_1234;
        tx_vals[1] = 32'h0000_00FF;
        tx_vals[2] = 32'h0000_0056;
        tx_vals[3] = 32'h89AB_CDEF;
        tx_vals[4] = 32'h0000_4321;
        tx_vals[5] = 32'h1122_3344;
        for (int i = 0; i < 6; i++) begin
            mst.put(mpm_pkg::FC_OBJ, mpm_pkg::TX_MAP_OBJ, 8'(i + 1), tx_map[i]);
            cx("tx entry", mpm_pkg::EXC_NONE, mst.oexc);
        end
        mst.put(mpm_pkg::FC_OBJ, mpm_pkg::TX_MAP_OBJ, mpm_pkg::SUB_CNT, 32'h6);
        cx("tx count", mpm_pkg::EXC_NONE, mst.oexc);
        mst.msg(mpm_pkg::FC_RD_HOLD, 1'b0, mpm_pkg::TX_BASE, 16'h0007, 7);
        cmp("lost", 32'h0, mst.lost);
        for (int i = 0; i < 7; i++) cmp("tx reg", tx_img[i], mst.rbuf[i]);
        mst.msg(mpm_pkg::FC_RD_IN, 1'b0, mpm_pkg::TX_BASE + 16'h0006, 16'h0001, 1);
        cmp("tx last", 32'h3344, mst.rbuf[0]);
        // object refusals, then the rx table
        for (int i = 0; i < 5; i++) begin
            {ob_f, ob_i, ob_s, ob_d, e} = bado[i];
            mst.put(ob_f, ob_i, ob_s, ob_d);
            cx("obj bad", e, mst.oexc);
        end
        for (int i = 0; i < 3; i++) begin
            mst.put(mpm_pkg::FC_OBJ, mpm_pkg::RX_MAP_OBJ, 8'(i + 1), rx_map[i]);
        end
        mst.put(mpm_pkg::FC_OBJ, mpm_pkg::RX_MAP_OBJ, mpm_pkg::SUB_CNT, 32'h3);
        cx("rx count", mpm_pkg::EXC_NONE, mst.oexc);
        mst.wbuf = '{0: 16'hAAAA, 1: 16'hBBBB, 2: 16'h1234, 3: 16'h5678, default: 16'hFFFF};
        mst.msg(mpm_pkg::FC_WR_MULTI, 1'b1, mpm_pkg::RX_BASE, 16'h0004, 4);
        cx("rx write", mpm_pkg::EXC_NONE, mst.ebuf[3]);
        cmp("rx upd", 32'h1, mst.upd);
        @(negedge ref_clk);
        cmp("rx v0", 32'h0000_AAAA, rx_vals[0]);
        cmp("rx dummy", 32'h0, rx_vals[1]);
        cmp("rx v2", 32'h1234_5678, rx_vals[2]);
        mst.msg(mpm_pkg::FC_RW_MULTI, 1'b0, mpm_pkg::RX_BASE, 16'h0004, 4);
        cmp("rx back", 32'hBBBB, mst.rbuf[1]);
        mst.wbuf[0] = 16'h9ABC;
        mst.msg(mpm_pkg::FC_WR_ONE, 1'b1, mpm_pkg::RX_BASE + 16'h0002, 16'h0001, 1);
        @(negedge ref_clk);
        cmp("rx one", 32'h9ABC_5678, rx_vals[2]);
        // refused messages have no effect
        mst.wbuf[0] = 16'hFFFF;
        mst.wbuf[1] = 16'hFFFF;
        for (int i = 0; i < 10; i++) begin
            {f, w, s, q, e} = bad[i];
            mst.msg(f, w, s, q, 1);
            cx("refused", e, mst.ebuf[0]);
        end
        cmp("uin kept", 32'h0, up_in[0]);
        // exchange arrays, whole aligned words only
        mst.msg(mpm_pkg::FC_RD_IN, 1'b0, mpm_pkg::UOUT_BASE + 16'h0002, 16'h0002, 2);
        cmp("uout hi", 32'hCAFE, mst.rbuf[0]);
        cmp("uout lo", 32'hF00D, mst.rbuf[1]);
        mst.wbuf[0] = 16'h1357;
        mst.wbuf[1] = 16'h9BDF;
        mst.msg(mpm_pkg::FC_WR_MULTI, 1'b1, mpm_pkg::UIN_BASE + 16'h0004, 16'h0002, 2);
        @(negedge ref_clk);
        cmp("uin word", 32'h1357_9BDF, up_in[2]);
        mst.msg(mpm_pkg::FC_RW_MULTI, 1'b0, mpm_pkg::UIN_BASE + 16'h0004, 16'h0002, 2);
        cmp("uin back", 32'h9BDF, mst.rbuf[1]);
        // tx slot 1 turned into a 16-bit dummy reads zero although its value is nonzero
        mst.put(mpm_pkg::FC_OBJ, mpm_pkg::TX_MAP_OBJ, 8'h01, 32'h0003_0010);
        cx("tx dummy map", mpm_pkg::EXC_NONE, mst.oexc);
        mst.msg(mpm_pkg::FC_RD_HOLD, 1'b0, mpm_pkg::TX_BASE, 16'h0001, 1);
        cmp("tx dummy", 32'h0, mst.rbuf[0]);
        conclude();
    end
endmodule : modbus_process_image_mapper_bench

// File: test/mpm_master.sv
// modbus master model: sends register beats and object writes, keeps the answers
// assumes the mapper answers every beat and object write one cycle after it is taken
`timescale 1ns/1ps
module mpm_master (
    // clock
    input wire logic ref_clk,
    // register beats
    output logic req_valid,
    output mpm_pkg::mpm_req_t req,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic [7:0] rsp_exc,
    input wire logic rx_update,
    // object writes
    output logic obj_valid,
    output mpm_pkg::mpm_obj_t obj,
    input wire logic obj_ack,
    input wire logic [7:0] obj_exc
);
    logic [15:0] wbuf [16]; // write data per beat
    logic [15:0] rbuf [16]; // read data per beat
    logic [7:0] ebuf [16]; // exception per beat
    logic [7:0] oexc; // object answer, EE when no ack came
    logic lost; // some beat got no answer pulse
    logic upd; // receive update pulse seen
    // idle bus at time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
        obj_valid = 1'b0;
        obj = '0;
    end
    // n beats back to back; each answer is picked up one cycle later
    task automatic msg(input logic [7:0] f, input logic w, input logic [15:0] st,
        input logic [15:0] qty, input int n);
        lost = 1'b0;
        upd = 1'b0;
        for (int i = 0; i <= n; i++) begin
            @(negedge ref_clk);
            if (i > 0) begin
                lost = lost | (rsp_valid !== 1'b1);
                upd = upd | (rx_update === 1'b1);
                rbuf[i-1] = rsp_data;
                ebuf[i-1] = rsp_exc;
            end
            if (i < n) begin
                req_valid = 1'b1;
                req = '{fc: f, wr: w, start: st, qty: qty, addr: st + 16'(i),
                        wdata: wbuf[i]};
            end else begin
                // released bus shows no stale value
                req_valid = 1'b0;
                req = mpm_pkg::mpm_req_t'(~req);
            end
        end
    endtask : msg
    // one object write, tables are only configured this way
    task automatic put(input logic [7:0] f, input logic [15:0] ix, input logic [7:0] sb,
        input logic [31:0] d);
        @(negedge ref_clk);
        obj_valid = 1'b1;
        obj = '{fc: f, index: ix, sub: sb, data: d};
        @(negedge ref_clk);
        obj_valid = 1'b0;
        obj = mpm_pkg::mpm_obj_t'(~obj);
        oexc = (obj_ack === 1'b1) ? obj_exc : 8'hEE;
    endtask : put
endmodule : mpm_master
